// File: common/acr_pkg.sv
// constants, codes and carrier types for the amplifier configuration bank
package acr_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_SWITCH = 8'h02;
  localparam logic [7:0] OFS_PORT   = 8'h03;
  localparam logic [7:0] OFS_CHAN   = 8'h04;
  localparam logic [7:0] RST_SWITCH = 8'h62;
  localparam logic [7:0] RST_PORT   = 8'h04;
  localparam logic [7:0] RST_CHAN   = 8'h55;
  localparam logic [7:0] MASK_SWITCH = 8'h77; // bits 7 and 3 held at zero
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PWM_MSB   = 6;
  localparam int PWM_LSB   = 4;
  localparam int OSR_BIT   = 2;
  localparam int PHASE_MSB = 1;
  localparam int PHASE_LSB = 0;
  localparam int RATE_MSB  = 7;
  localparam int RATE_LSB  = 6;
  localparam int UPPER_BIT = 5;
  localparam int SLOT16_BIT = 4;
  localparam int SWAP_BIT  = 3;
  localparam int FMT_MSB   = 2;
  localparam int FMT_LSB   = 0;
  localparam int CH_COUNT  = 4;

  // ****************************************
  // switching codes and decoded values
  // ****************************************
  localparam logic [2:0] PWM_8X  = 3'h0;
  localparam logic [2:0] PWM_10X = 3'h1;
  localparam logic [2:0] PWM_38X = 3'h5;
  localparam logic [2:0] PWM_44X = 3'h6;
  localparam logic [2:0] PWM_48X = 3'h7;
  localparam logic [5:0] MULT_8  = 6'h08;
  localparam logic [5:0] MULT_10 = 6'h0a;
  localparam logic [5:0] MULT_38 = 6'h26;
  localparam logic [5:0] MULT_44 = 6'h2c;
  localparam logic [5:0] MULT_48 = 6'h30;
  localparam logic [5:0] PHASE_DEG0  = 6'h00;
  localparam logic [5:0] PHASE_DEG30 = 6'h1e;
  localparam logic [5:0] PHASE_DEG45 = 6'h2d;
  localparam logic [5:0] PHASE_DEG60 = 6'h3c;
  localparam logic [1:0] RATE_44K1 = 2'h0;
  localparam logic [1:0] RATE_48K  = 2'h1;
  localparam logic [1:0] RATE_96K  = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [4:0] RJ_BITS24 = 5'h18;
  localparam logic [4:0] RJ_BITS20 = 5'h14;
  localparam logic [4:0] RJ_BITS18 = 5'h12;
  localparam logic [4:0] RJ_BITS16 = 5'h10;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'b000, FMT_RJ20 = 3'b001, FMT_RJ18 = 3'b010, FMT_RJ16 = 3'b011,
    FMT_I2S  = 3'b100, FMT_LJ   = 3'b101, FMT_TDM  = 3'b110, FMT_RSVD = 3'b111
  } acr_fmt_e;

  typedef enum logic [1:0] {
    CS_PLAY = 2'b00, CS_HIGHZ = 2'b01, CS_MUTE = 2'b10, CS_DIAG = 2'b11
  } acr_chan_e;

  // ****************************************
  // carrier structs
  // ****************************************
  typedef struct packed {
    logic [5:0] pwmMultiple; // switching rate / sample rate, 0 when reserved
    logic       pwmCodeBad;  // reserved switching code stored
    logic       osr128;      // modulator oversampling 128x
    logic [5:0] phaseDeg;    // inter-channel phase offset in degrees
  } acr_switch_s;

  typedef struct packed {
    logic [1:0] rate;        // expected sample rate code
    logic       rateBad;     // reserved rate code stored
    logic       slot16;      // 16-bit tdm slots
    acr_fmt_e   format;      // input format
    logic [4:0] rjBits;      // right-justified word width, 0 otherwise
    logic       fmtBad;      // reserved format code stored
  } acr_port_s;

endpackage

// File: hdl/acr_config_regs.sv
// configuration register bank for switching, audio port and channel state
`timescale 1ns/1ps

module acr_config_regs #(
  parameter int CHANNELS = acr_pkg::CH_COUNT
) (
  input  wire logic                 clk,         // 100 MHz clock
  input  wire logic                 rst,         // synchronous reset, high
  input  wire logic                 regWrite,    // write strobe, one cycle
  input  wire logic                 regRead,     // read strobe, one cycle
  input  wire logic [7:0]           regAddr,     // register offset
  input  wire logic [7:0]           regWdata,    // write data
  output      logic [7:0]           regRdata,    // read data, held
  output      acr_pkg::acr_switch_s switchCfg,   // decoded switching setup
  output      acr_pkg::acr_port_s   portCfg,     // decoded audio port setup
  output      logic [CHANNELS-1:0][2:0] slotMap, // tdm slot per channel
  output      logic [CHANNELS-1:0]  chanPlay,    // channel playing
  output      logic [CHANNELS-1:0]  chanHighZ,   // channel high impedance
  output      logic [CHANNELS-1:0]  chanMute,    // channel muted
  output      logic [CHANNELS-1:0]  chanDiag,    // channel in dc diagnostics
  output      logic                 comboBad     // 48x with 48 kHz stored
);
  import acr_pkg::*;

  // ****************************************
  // elaboration check
  // ****************************************
  if (CHANNELS != CH_COUNT) begin : g_bad_channels
    $error("channel count must be four");
  end

  logic [7:0] switchReg;
  logic [7:0] portReg;
  logic [7:0] chanReg;

  // ****************************************
  // register storage
  // ****************************************
  // switching setup, reserved bits masked
  always_ff @(posedge clk) begin
    if (rst) begin
      switchReg <= RST_SWITCH;
    end else if (regWrite && regAddr == OFS_SWITCH) begin
      switchReg <= regWdata & MASK_SWITCH;
    end
  end

  // audio port setup
  always_ff @(posedge clk) begin
    if (rst) begin
      portReg <= RST_PORT;
    end else if (regWrite && regAddr == OFS_PORT) begin
      portReg <= regWdata;
    end
  end

  // per-channel state
  always_ff @(posedge clk) begin
    if (rst) begin
      chanReg <= RST_CHAN;
    end else if (regWrite && regAddr == OFS_CHAN) begin
      chanReg <= regWdata;
    end
  end

  // read port, unmapped offsets answer zero
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= RD_UNMAPPED;
    end else if (regRead) begin
      case (regAddr)
        OFS_SWITCH: regRdata <= switchReg;
        OFS_PORT:   regRdata <= portReg;
        OFS_CHAN:   regRdata <= chanReg;
        default:    regRdata <= RD_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // switching decode
  // ****************************************
  // rate multiple, reserved codes flagged
  always_ff @(posedge clk) begin
    if (rst) begin
      switchCfg.pwmMultiple <= MULT_44;
      switchCfg.pwmCodeBad  <= 1'b0;
    end else begin
      switchCfg.pwmCodeBad <= 1'b0;
      case (switchReg[PWM_MSB:PWM_LSB])
        PWM_8X:  switchCfg.pwmMultiple <= MULT_8;
        PWM_10X: switchCfg.pwmMultiple <= MULT_10;
        PWM_38X: switchCfg.pwmMultiple <= MULT_38;
        PWM_44X: switchCfg.pwmMultiple <= MULT_44;
        PWM_48X: switchCfg.pwmMultiple <= MULT_48;
        default: begin
          switchCfg.pwmMultiple <= 6'h00;
          switchCfg.pwmCodeBad  <= 1'b1;
        end
      endcase
    end
  end

  // oversampling and phase offset
  always_ff @(posedge clk) begin
    if (rst) begin
      switchCfg.osr128   <= 1'b0;
      switchCfg.phaseDeg <= PHASE_DEG45;
    end else begin
      switchCfg.osr128 <= switchReg[OSR_BIT];
      case (switchReg[PHASE_MSB:PHASE_LSB])
        2'h0:    switchCfg.phaseDeg <= PHASE_DEG0;
        2'h1:    switchCfg.phaseDeg <= PHASE_DEG30;
        2'h2:    switchCfg.phaseDeg <= PHASE_DEG45;
        default: switchCfg.phaseDeg <= PHASE_DEG60;
      endcase
    end
  end

  // unsupported pairing left to the host, only reported here
  always_ff @(posedge clk) begin
    if (rst) begin
      comboBad <= 1'b0;
    end else begin
      comboBad <= switchReg[PWM_MSB:PWM_LSB] == PWM_48X
                  && portReg[RATE_MSB:RATE_LSB] == RATE_48K;
    end
  end

  // ****************************************
  // audio port decode
  // ****************************************
  // rate and slot width
  always_ff @(posedge clk) begin
    if (rst) begin
      portCfg.rate    <= RATE_44K1;
      portCfg.rateBad <= 1'b0;
      portCfg.slot16  <= 1'b0;
    end else begin
      portCfg.rate    <= portReg[RATE_MSB:RATE_LSB];
      portCfg.rateBad <= portReg[RATE_MSB:RATE_LSB] == RATE_RSVD;
      portCfg.slot16  <= portReg[SLOT16_BIT];
    end
  end

  // format and right-justified width
  always_ff @(posedge clk) begin
    if (rst) begin
      portCfg.format <= FMT_I2S;
      portCfg.rjBits <= 5'h00;
      portCfg.fmtBad <= 1'b0;
    end else begin
      portCfg.format <= acr_fmt_e'(portReg[FMT_MSB:FMT_LSB]);
      portCfg.fmtBad <= portReg[FMT_MSB:FMT_LSB] == FMT_RSVD;
      case (portReg[FMT_MSB:FMT_LSB])
        FMT_RJ24: portCfg.rjBits <= RJ_BITS24;
        FMT_RJ20: portCfg.rjBits <= RJ_BITS20;
        FMT_RJ18: portCfg.rjBits <= RJ_BITS18;
        FMT_RJ16: portCfg.rjBits <= RJ_BITS16;
        default:  portCfg.rjBits <= 5'h00;
      endcase
    end
  end

  // ****************************************
  // per-channel decode
  // ****************************************
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    localparam logic [1:0] CH_IDX = 2'(ch);
    logic [1:0] field;
    assign field = chanReg[7-2*ch -: 2];

    // state flags, channel 0 in the top field
    always_ff @(posedge clk) begin
      if (rst) begin
        chanPlay[ch]  <= 1'b0;
        chanHighZ[ch] <= 1'b1;
        chanMute[ch]  <= 1'b0;
        chanDiag[ch]  <= 1'b0;
      end else begin
        chanPlay[ch]  <= field == CS_PLAY;
        chanHighZ[ch] <= field == CS_HIGHZ;
        chanMute[ch]  <= field == CS_MUTE;
        chanDiag[ch]  <= field == CS_DIAG;
      end
    end

    // slot index: pair swap flips the middle index bit, group adds four
    always_ff @(posedge clk) begin
      if (rst) begin
        slotMap[ch] <= {1'b0, CH_IDX};
      end else begin
        slotMap[ch] <= {portReg[UPPER_BIT],
                        CH_IDX[1] ^ portReg[SWAP_BIT],
                        CH_IDX[0]};
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // register storage, masking, read port and decoded reset state
  a_reset_values: assert property ($past(rst) |->
      switchReg == 8'h62 && portReg == 8'h04 && chanReg == 8'h55)
    else $error("register reset values wrong");
  a_resv_zero: assert property (switchReg[7] == 1'b0 && switchReg[3] == 1'b0)
    else $error("reserved switching bits not zero");
  a_switch_write: assert property (regWrite && regAddr == 8'h02 |=>
      switchReg == ($past(regWdata) & 8'h77))
    else $error("switching register write lost");
  a_port_write: assert property (regWrite && regAddr == 8'h03 |=>
      portReg == $past(regWdata))
    else $error("audio port register write lost");
  a_chan_write: assert property (regWrite && regAddr == 8'h04 |=>
      chanReg == $past(regWdata))
    else $error("channel state register write lost");
  a_switch_read: assert property (regRead && regAddr == 8'h02 |=>
      regRdata == $past(switchReg) && !regRdata[7] && !regRdata[3])
    else $error("switching register read back wrong");
  a_port_read: assert property (regRead && regAddr == 8'h03 |=>
      regRdata == $past(portReg))
    else $error("audio port read back wrong");
  a_chan_read: assert property (regRead && regAddr == 8'h04 |=>
      regRdata == $past(chanReg))
    else $error("channel state read back wrong");
  a_decode_reset: assert property ($past(rst) |->
      switchCfg.pwmMultiple == 6'd44 && !switchCfg.osr128 && switchCfg.phaseDeg == 6'd45
      && portCfg.format == FMT_I2S && chanHighZ == 4'hf)
    else $error("decoded reset state wrong");

  // switching decode
  a_pwm_decode: assert property (switchReg[6:4] == 3'b101 ##1 switchReg[6:4] == 3'b101
      |-> switchCfg.pwmMultiple == 6'd38 && !switchCfg.pwmCodeBad)
    else $error("switching multiple decode wrong");
  a_pwm_slow: assert property (switchReg[6:4] == 3'b001 |=>
      switchCfg.pwmMultiple == 6'd10 && !switchCfg.pwmCodeBad)
    else $error("10x switching decode wrong");
  a_pwm_fast: assert property (switchReg[6:4] == 3'b111 |=>
      switchCfg.pwmMultiple == 6'd48 && !switchCfg.pwmCodeBad)
    else $error("48x switching decode wrong");
  a_pwm_reserved: assert property (switchReg[6:4] == 3'b011 |=>
      switchCfg.pwmCodeBad && switchCfg.pwmMultiple == 6'd0)
    else $error("reserved switching code not flagged");
  a_phase_osr: assert property (switchReg[2:0] == 3'b101 |=>
      switchCfg.phaseDeg == 6'd30 && switchCfg.osr128)
    else $error("phase or oversampling decode wrong");
  a_combo_flag: assert property (comboBad ==
      $past(switchReg[6:4] == 3'b111 && portReg[7:6] == 2'b01))
    else $error("48x with 48 kHz report wrong");

  // audio port decode
  a_slot_map: assert property (portReg[5] && portReg[3] |=>
      slotMap[0] == 3'd6 && slotMap[3] == 3'd5)
    else $error("slot map wrong for swap and upper group");
  a_slot_plain: assert property (!portReg[5] && !portReg[3] |=>
      slotMap[1] == 3'd1 && slotMap[2] == 3'd2)
    else $error("plain slot map wrong");
  a_rate_fmt: assert property (portReg[7:6] == 2'b10 && portReg[4]
      && portReg[2:0] == 3'b010 |=> portCfg.rate == 2'd2 && portCfg.slot16 && portCfg.rjBits == 5'd18)
    else $error("audio port decode wrong");
  a_rate_rsvd: assert property (portReg[7:6] == 2'b11 |=>
      portCfg.rateBad && portCfg.rate == 2'd3)
    else $error("reserved rate not flagged");
  a_rj_wide: assert property (portReg[2:0] == 3'b000 |=>
      portCfg.rjBits == 5'd24 && portCfg.format == FMT_RJ24)
    else $error("24-bit right-justified decode wrong");
  a_lj_format: assert property (portReg[2:0] == 3'b101 |=>
      portCfg.format == FMT_LJ && portCfg.rjBits == 5'd0)
    else $error("left-justified decode wrong");
  a_tdm_format: assert property (portReg[2:0] == 3'b110 |=>
      portCfg.format == FMT_TDM && portCfg.rjBits == 5'd0)
    else $error("tdm format decode wrong");
  a_fmt_rsvd: assert property (portReg[2:0] == 3'b111 |=>
      portCfg.fmtBad && portCfg.rjBits == 5'd0)
    else $error("reserved format not flagged");

  // channel state decode
  a_chan_state: assert property (chanReg[7:6] == 2'b10 && chanReg[1:0] == 2'b00 |=>
      chanMute[0] && !chanPlay[0] && chanPlay[3] && !chanHighZ[3])
    else $error("channel state decode wrong");
  a_diag_state: assert property (chanReg[1:0] == 2'b11 |=>
      chanDiag[3] && !chanMute[3] && !chanPlay[3])
    else $error("diagnostics state decode wrong");
  a_highz_state: assert property (chanReg[5:4] == 2'b01 |=>
      chanHighZ[1] && !chanDiag[1] && !chanPlay[1])
    else $error("high impedance state decode wrong");

  // main scenarios
  c_combo_bad: cover property (comboBad);
  c_swap_upper: cover property (portReg[5] && portReg[3] && portReg[2:0] == 3'b110);
  c_all_play: cover property (chanPlay == 4'hf);
  c_fmt_reserved: cover property (portCfg.fmtBad);
  c_chan_diag: cover property (chanDiag == 4'h8);

endmodule

// File: verif/acr_host_model.sv
// host-side driver of the configuration bank register port
`timescale 1ns/1ps

module acr_host_model (
  input  wire logic       clk,      // bank clock
  output      logic       regWrite, // write strobe
  output      logic       regRead,  // read strobe
  output      logic [7:0] regAddr,  // register offset
  output      logic [7:0] regWdata, // write data
  input  wire logic [7:0] regRdata  // read data
);
  import acr_pkg::*;

  logic [7:0] lastSwitch; // switching value last written
  logic [7:0] lastPort;   // port value last written

  // idle bus from time zero
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    lastSwitch = RST_SWITCH;
    lastPort = RST_PORT;
  end

  // one write strobe, withheld if it would pair 48x with 48 kHz
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic bad;
    bad = (addr == OFS_SWITCH && data[6:4] == PWM_48X && lastPort[7:6] == RATE_48K) ||
          (addr == OFS_PORT && data[7:6] == RATE_48K && lastSwitch[6:4] == PWM_48X);
    if (bad) begin
      $display("host withheld write to %h", addr);
    end else begin
      @(posedge clk);
      #1;
      regWrite = 1'b1;
      regAddr = addr;
      regWdata = data;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      regAddr = ~addr;
      regWdata = ~data;
      if (addr == OFS_SWITCH) lastSwitch = data;
      if (addr == OFS_PORT) lastPort = data;
    end
  endtask

  // one read strobe, data taken once the answer has landed
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    regRead = 1'b1;
    regAddr = addr;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    regAddr = ~addr;
    @(posedge clk);
    #1;
    data = regRdata;
  endtask
endmodule

// File: verif/amp_output_and_audio_port_config_tb.sv
// self-checking bench for the amplifier configuration bank
`timescale 1ns/1ps

module amp_output_and_audio_port_config_tb;
  import acr_pkg::*;

  logic            clk;
  logic            rst;
  logic            regWrite, regRead, comboBad;
  logic [7:0]      regAddr, regWdata, regRdata, rv;
  acr_switch_s     swc;
  acr_port_s       prt;
  logic [3:0][2:0] slotMap;
  logic [3:0]      chanPlay, chanHighZ, chanMute, chanDiag;
  int              n_errors, num_checks, cycles;
  localparam logic [5:0] MULT_TAB [8] = '{MULT_8, MULT_10, 6'h00, 6'h00, 6'h00, MULT_38, MULT_44, MULT_48};
  localparam logic [5:0] DEG_TAB [4] = '{PHASE_DEG0, PHASE_DEG30, PHASE_DEG45, PHASE_DEG60};
  localparam logic [4:0] RJ_TAB [4] = '{RJ_BITS24, RJ_BITS20, RJ_BITS18, RJ_BITS16};
  localparam logic [7:0] CS_TAB [4] = '{8'h1b, 8'hb4, 8'h4e, 8'he1}; // each state once per channel

  acr_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
                       .regWdata(regWdata), .regRdata(regRdata));
  acr_config_regs #(.CHANNELS(CH_COUNT)) DUT (.clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .switchCfg(swc), .portCfg(prt),
    .slotMap(slotMap), .chanPlay(chanPlay), .chanHighZ(chanHighZ), .chanMute(chanMute),
    .chanDiag(chanDiag), .comboBad(comboBad));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cut a hang short
  initial cycles = 0;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(what, 16'(e), 16'(rv));
  endtask

  // let register and decode edges land
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0]  d;
    logic [11:0] sm;
    logic [15:0] ce;
    logic [1:0]  f;
    rst = 1'b1;
    n_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk("switch reg", OFS_SWITCH, RST_SWITCH);
    rchk("port reg", OFS_PORT, RST_PORT);
    rchk("chan reg", OFS_CHAN, RST_CHAN);
    chk("switch decode", 16'(swc), 16'({MULT_44, 1'b0, 1'b0, PHASE_DEG45}));
    chk("port decode", 16'(prt), 16'({RATE_44K1, 1'b0, 1'b0, FMT_I2S, 5'h00, 1'b0}));
    chk("slot map", 16'(slotMap), 16'({3'h3, 3'h2, 3'h1, 3'h0}));
    chk("high impedance", 16'(chanHighZ), 16'h000f);
    $display("test reset done");
    // every switching code, reserved bits written high
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, 3'(i), 1'b1, i[0], i[1:0]};
      host.wr(OFS_SWITCH, d);
      settle();
      rchk("switch readback", OFS_SWITCH, d & MASK_SWITCH);
      chk("switch decode", 16'(swc), 16'({MULT_TAB[i], i >= 2 && i <= 4, i[0], DEG_TAB[i[1:0]]}));
    end
    host.wr(OFS_SWITCH, RST_SWITCH);
    $display("test switching done");
    // every format, rate and slot option
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], i[0], i[1], i[2], 3'(i)};
      host.wr(OFS_PORT, d);
      settle();
      rchk("port readback", OFS_PORT, d);
      chk("port decode", 16'(prt), 16'({i[1:0], i[1:0] == RATE_RSVD, i[1], 3'(i),
                                        i < 4 ? RJ_TAB[i[1:0]] : 5'h00, i == 7}));
      for (int c = 0; c < 4; c++) begin
        sm[3*c +: 3] = {i[0], c[1] ^ i[2], c[0]};
      end
      chk("slot map", 16'(slotMap), 16'(sm));
    end
    chk("combo flag", 16'(comboBad), 16'h0000);
    // 48 kHz stored, so the host must hold back 48x switching
    host.wr(OFS_PORT, 8'h44);
    host.wr(OFS_SWITCH, 8'h72);
    settle();
    rchk("withheld switch", OFS_SWITCH, RST_SWITCH);
    chk("combo flag withheld", 16'(comboBad), 16'h0000);
    $display("test audio port done");
    // every channel state on every channel
    for (int k = 0; k < 4; k++) begin
      d = CS_TAB[k];
      host.wr(OFS_CHAN, d);
      settle();
      rchk("chan readback", OFS_CHAN, d);
      ce = 16'h0000;
      for (int c = 0; c < 4; c++) begin
        f = d[6-2*c +: 2];
        ce[12 - 4*f + c] = 1'b1;
      end
      chk("chan states", ce, {chanPlay, chanHighZ, chanMute, chanDiag});
    end
    host.wr(OFS_CHAN, 8'h00);
    settle();
    chk("all play", 16'(chanPlay), 16'h000f);
    $display("test channel state done");
    // stray write and read of an unmapped offset
    host.wr(8'h05, 8'hff);
    rchk("unmapped", 8'h05, RD_UNMAPPED);
    rchk("chan after stray write", OFS_CHAN, 8'h00);
    $display("test unmapped done");
    // every register off its reset value, the switching one written here, then reset in mid-run
    host.wr(OFS_SWITCH, 8'h15);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk("switch after reset", OFS_SWITCH, RST_SWITCH);
    rchk("port after reset", OFS_PORT, RST_PORT);
    rchk("chan after reset", OFS_CHAN, RST_CHAN);
    chk("switch decode after reset", 16'(swc), 16'({MULT_44, 1'b0, 1'b0, PHASE_DEG45}));
    chk("high impedance after reset", 16'(chanHighZ), 16'h000f);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
